// [hw/tdm_pkg.sv]
`default_nettype none
// =====================================================================
// Constants for the audio link and current stream.
package tdm_pkg;
    // =================================================================
    // Clocking and timing.
    localparam int unsigned CLK_MHZ  = 100;
    // Bit clock silence longer than this is clock loss.
    localparam int unsigned LOSS_NS  = 1000;
    localparam logic [11:0] LOSS_CYC =
        12'((LOSS_NS * CLK_MHZ) / 1000);
    // Host bit clock half period in clocks, minus one.
    localparam logic [2:0]  BCLK_HALF_LAST = 3'h7;

    // =================================================================
    // Word layout.
    localparam int unsigned WORD_BITS   = 32;
    localparam int unsigned AUDIO_BITS  = 24;
    localparam int unsigned CUR_BITS    = 15;
    localparam logic [4:0]  SLOT_LAST   = 5'h1F;
    localparam logic [4:0]  CUR_BITS_5  = 5'h0F;
    localparam logic [9:0]  CNT_MAX     = 10'h3FF;
    localparam logic [14:0] CUR_MAX     = 15'h3FFF;
    localparam logic [14:0] CUR_MIN     = 15'h4000;
    localparam int unsigned FRAC_SHIFT  = 5;

    // =================================================================
    // Field encodings.
    localparam logic [1:0] FMT_STD   = 2'h0;
    localparam logic [1:0] FMT_TDM4  = 2'h1;
    localparam logic [1:0] FMT_TDM8  = 2'h2;
    localparam logic [1:0] FMT_TDM16 = 2'h3;
    localparam logic [9:0] FB_STD    = 10'h040;
    localparam logic [9:0] FB_TDM4   = 10'h080;
    localparam logic [9:0] FB_TDM8   = 10'h100;
    localparam logic [9:0] FB_TDM16  = 10'h200;
    localparam logic [2:0] RATE_44K1 = 3'h0;
    localparam logic [2:0] RATE_48K  = 3'h1;
    localparam logic [2:0] RATE_96K  = 3'h2;
    localparam logic [2:0] RATE_192K = 3'h3;
    localparam logic [1:0] OS_00     = 2'h0;
    localparam logic [1:0] OS_10     = 2'h2;
    localparam logic [2:0] MON_ENABLE = 3'h3;
    // Fraction of the 15-bit range at full scale, in 32nds.
    localparam logic [3:0] FRAC_OS00  = 4'h7;
    localparam logic [3:0] FRAC_OS01  = 4'h8;
    localparam logic [3:0] FRAC_OS10  = 4'h9;
    localparam logic [3:0] FRAC_96K   = 4'h4;
    localparam logic [3:0] FRAC_192K  = 4'h2;

    // =================================================================
    // Device configuration reset values.
    localparam logic [1:0] FMT_RST  = FMT_STD;
    localparam logic [3:0] SLOT_RST = 4'h0;
    localparam logic [2:0] RATE_RST = RATE_48K;
    localparam logic [1:0] OS_RST   = 2'h1;
    localparam logic [2:0] MON_RST  = 3'h0;
    localparam logic [1:0] FSR_8A   = 2'h0;

    // Bits in one frame of a framing.
    function automatic logic [9:0] frame_bits(input logic [1:0] fmt);
        case (fmt)
            FMT_STD:  frame_bits = FB_STD;
            FMT_TDM4: frame_bits = FB_TDM4;
            FMT_TDM8: frame_bits = FB_TDM8;
            default:  frame_bits = FB_TDM16;
        endcase
    endfunction : frame_bits

    // Full-scale fraction per rate and oversampling.
    function automatic logic [3:0] cur_frac(input logic [2:0] rate,
                                            input logic [1:0] os);
        if (rate == RATE_96K) begin
            cur_frac = FRAC_96K;
        end else if (rate == RATE_192K) begin
            cur_frac = FRAC_192K;
        end else if (os == OS_00) begin
            cur_frac = FRAC_OS00;
        end else if (os == OS_10) begin
            cur_frac = FRAC_OS10;
        end else begin
            cur_frac = FRAC_OS01;
        end
    endfunction : cur_frac
endpackage : tdm_pkg
`default_nettype wire

// [hw/tdm_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Serial audio link between host processor and amplifier.
interface tdm_link_if;
    logic bit_clock_pin;          // Bit clock, made by the host.
    logic word_select_pin;        // Frame marker, from the host.
    logic serial_data_in_pin;     // Audio data, host to device.
    logic current_stream_out_pin; // Current words, device to host.

    modport dev_mp (
        input  bit_clock_pin,
        input  word_select_pin,
        input  serial_data_in_pin,
        output current_stream_out_pin
    );
    modport host_mp (
        output bit_clock_pin,
        output word_select_pin,
        output serial_data_in_pin,
        input  current_stream_out_pin
    );
endinterface : tdm_link_if
`default_nettype wire

// [hw/tdm_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Two-flop synchroniser; edges found after the second flop.
module tdm_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,  // System clock.
    input  wire logic         rst,  // Asynchronous reset, active high.
    input  wire logic         ce,   // Clock enable.
    input  wire logic [W-1:0] d,    // Asynchronous inputs.
    output logic      [W-1:0] q,    // Synchronised levels.
    output logic      [W-1:0] rise, // One-cycle rising pulses.
    output logic      [W-1:0] fall  // One-cycle falling pulses.
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } tdm_sync_state_type;

    tdm_sync_state_type st_q;
    tdm_sync_state_type st_d;

    // The first stage feeds only the second, never the edge logic.
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // =================================================================
    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign q    = st_q.s2;
    assign rise = st_q.s2 & ~st_q.s3;
    assign fall = ~st_q.s2 & st_q.s3;
endmodule : tdm_sync
`default_nettype wire

// [hw/tdm_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module tdm_dev (
    input  wire logic               clk,                    // Clock.
    input  wire logic               rst,                    // Reset.
    input  wire logic               ce,                     // Enable.
    tdm_link_if.dev_mp              link,                   // Link.
    input  wire logic               cfg_write,              // Load cfg.
    input  wire logic [1:0]         frame_format_field,     // Framing.
    input  wire logic [3:0]         slot_select_field,      // Slot.
    input  wire logic [2:0]         sample_rate_field,      // Rate.
    input  wire logic [1:0]         oversample_setting,     // Oversamp.
    input  wire logic [2:0]         monitor_mode_field,     // Monitor.
    input  wire logic [1:0]         sense_full_scale_field, // Range.
    input  wire logic               monitor_edge_select,    // 1 rising.
    input  wire logic               amp_mute_or_play,       // Amp state.
    input  wire logic signed [15:0] sense_pos,              // Pos curr.
    input  wire logic signed [15:0] sense_neg,              // Neg curr.
    input  wire logic               frame_error_clear,      // Clear flag.
    output logic [23:0]             audio_sample,           // Audio word.
    output logic                    audio_valid,            // Word pulse.
    output logic                    frame_error_flag,       // Sticky.
    output logic                    force_standby           // Clock lost.
);
    typedef struct packed {
        logic [1:0]  fmt;
        logic [3:0]  slot;
        logic [2:0]  rate;
        logic [1:0]  os;
        logic [2:0]  mon;
        logic [1:0]  fsr;
        logic        edge_sel;
        logic        ws;
        logic        framed;
        logic [9:0]  cnt;
        logic [31:0] shreg;
        logic [23:0] audio;
        logic        audio_vld;
        logic [14:0] cur_code;
        logic        cur_pin;
        logic        ferr;
        logic [11:0] loss_cnt;
        logic        lost;
    } tdm_dev_state_type;

    localparam tdm_dev_state_type DEV_RST = '{
        fmt:     tdm_pkg::FMT_RST,
        slot:    tdm_pkg::SLOT_RST,
        rate:    tdm_pkg::RATE_RST,
        os:      tdm_pkg::OS_RST,
        mon:     tdm_pkg::MON_RST,
        fsr:     tdm_pkg::FSR_8A,
        cnt:     tdm_pkg::CNT_MAX,
        default: '0
    };

    tdm_dev_state_type       q;
    tdm_dev_state_type       d;
    logic [2:0]              pin_s;
    logic [2:0]              pin_rise;
    logic [2:0]              pin_fall;
    logic                    brise;
    logic                    bfall;
    logic signed [16:0]      diff;
    logic signed [15:0]      sensed_current;
    logic signed [23:0]      scaled;
    logic [14:0]             code;
    logic [9:0]              fb;
    logic [9:0]              idx;
    logic [9:0]              nx;
    logic [14:0]             sh_code;
    logic                    start;
    logic                    mon_on;
    logic                    set_err;
    logic                    launch;

    // =================================================================
    // Pin synchronisers; all three share one latency, so stay aligned.
    tdm_sync #(.W(3)) u_pin_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .d    ({link.bit_clock_pin, link.word_select_pin,
                link.serial_data_in_pin}),
        .q    (pin_s),
        .rise (pin_rise),
        .fall (pin_fall)
    );
    assign brise = pin_rise[2];
    assign bfall = pin_fall[2];

    // =================================================================
    // Current scaling: half difference, range, fraction, saturate.
    always_comb begin
        diff   = {sense_pos[15], sense_pos} - {sense_neg[15], sense_neg};
        sensed_current    = diff[16:1];
        scaled = ($signed({{8{sensed_current[15]}}, sensed_current}) <<< q.fsr)
                 * $signed({20'h0_0000,
                            tdm_pkg::cur_frac(q.rate, q.os)})
                 >>> tdm_pkg::FRAC_SHIFT;
        if (scaled[23:14] != {10{scaled[23]}}) begin
            code = scaled[23] ? tdm_pkg::CUR_MIN : tdm_pkg::CUR_MAX;
        end else begin
            code = scaled[14:0];
        end
    end

    // =================================================================
    // Framing, receive, frame check, launch and loss watch.
    always_comb begin
        d           = q;
        d.audio_vld = 1'b0;
        fb          = tdm_pkg::frame_bits(q.fmt);
        start       = 1'b0;
        set_err     = 1'b0;
        idx         = q.cnt;
        nx          = q.cnt;
        sh_code     = '0;
        // Stream only when enabled and the amplifier can measure.
        mon_on      = (q.mon == tdm_pkg::MON_ENABLE)
                      && amp_mute_or_play && !q.lost;
        launch      = q.edge_sel ? brise : bfall;

        // Config loads at once so framing never sees a mix.
        if (cfg_write) begin
            d.fmt      = frame_format_field;
            d.slot     = slot_select_field;
            d.rate     = sample_rate_field;
            d.os       = oversample_setting;
            d.mon      = monitor_mode_field;
            d.fsr      = sense_full_scale_field;
            d.edge_sel = monitor_edge_select;
        end

        if (brise) begin
            d.ws  = pin_s[1];
            start = pin_s[1] & ~q.ws;
            if (start) begin
                // Check the length of the frame just ended.
                if (q.framed && (q.cnt != fb)) begin
                    set_err = 1'b1;
                end
                d.framed   = 1'b1;
                d.cur_code = mon_on ? code : '0;
                idx        = '0;
            end
            d.shreg = {q.shreg[30:0], pin_s[0]};
            // Last bit of the chosen slot: keep the top 24.
            if ((q.framed || start) && (idx < fb)
                && (idx[4:0] == tdm_pkg::SLOT_LAST)
                && (idx[8:5] == q.slot)) begin
                d.audio     = d.shreg[31:8];
                d.audio_vld = 1'b1;
            end
            d.cnt = (idx == tdm_pkg::CNT_MAX) ? idx : idx + 10'h001;
            nx    = idx + 10'h001;
        end

        // Next bit the host samples; wraps at frame end.
        if (nx >= fb) begin
            nx = '0;
        end
        if (launch) begin
            sh_code   = d.cur_code << nx[3:0];
            d.cur_pin = mon_on && d.framed && (nx[8:5] == q.slot)
                        && (nx[4:0] < tdm_pkg::CUR_BITS_5)
                        && sh_code[14];
        end

        // Sticky error: a new error wins over a clear in one cycle.
        d.ferr = (q.ferr & ~frame_error_clear) | set_err;

        // Any bit clock edge restarts the watch.
        if (brise || bfall) begin
            d.loss_cnt = '0;
        end else if (q.loss_cnt != tdm_pkg::LOSS_CYC) begin
            d.loss_cnt = q.loss_cnt + 12'h001;
        end
        d.lost = (d.loss_cnt == tdm_pkg::LOSS_CYC);
        if (d.lost) begin
            // Framing must be relearned once the clock returns.
            d.framed  = 1'b0;
            d.cnt     = tdm_pkg::CNT_MAX;
            d.cur_pin = 1'b0;
        end
    end

    // =================================================================
    // State register; the clock enable freezes everything.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= DEV_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign audio_sample                = q.audio;
    assign audio_valid                 = q.audio_vld;
    assign frame_error_flag            = q.ferr;
    assign force_standby               = q.lost;
    assign link.current_stream_out_pin = q.cur_pin;
endmodule : tdm_dev
`default_nettype wire

// [hw/tdm_host.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Host end: drives clock, frames and data; reads current.
module tdm_host (
    input  wire logic        clk,                // System clock.
    input  wire logic        rst,                // Reset, active high.
    input  wire logic        ce,                 // Clock enable.
    tdm_link_if.host_mp      link,               // Link.
    input  wire logic [1:0]  frame_format_field, // Framing.
    input  wire logic [3:0]  slot_select_field,  // Current slot.
    input  wire logic [31:0] tx_data,            // Next slot word.
    output logic             tx_take,            // Word taken pulse.
    output logic [14:0]      cur_word,           // Current word.
    output logic             cur_valid           // Word pulse.
);
    typedef struct packed {
        logic [2:0]  div;
        logic        bclk;
        logic        ws;
        logic [9:0]  cnt;
        logic [31:0] tx_sh;
        logic        take;
        logic [31:0] rx_sh;
        logic [14:0] cur;
        logic        cur_vld;
    } tdm_host_state_type;

    localparam tdm_host_state_type HOST_RST = '{
        cnt:     tdm_pkg::CNT_MAX,
        default: '0
    };

    tdm_host_state_type q;
    tdm_host_state_type d;
    logic               cur_s;
    logic [9:0]         fb;
    logic [9:0]         nx;

    // Current stream comes from the far end: synchronise it.
    tdm_sync #(.W(1)) u_cur_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .d    (link.current_stream_out_pin),
        .q    (cur_s),
        .rise (),
        .fall ()
    );

    // =================================================================
    // Divider; data and frame move at the fall, settled by the rise.
    always_comb begin
        d         = q;
        d.take    = 1'b0;
        d.cur_vld = 1'b0;
        fb        = tdm_pkg::frame_bits(frame_format_field);
        nx        = q.cnt + 10'h001;
        if (nx >= fb) begin
            nx = '0;
        end
        if (q.div == tdm_pkg::BCLK_HALF_LAST) begin
            d.div  = '0;
            d.bclk = ~q.bclk;
            if (q.bclk) begin
                d.cnt = nx;
                // Standard mode: high for one 32-bit slot; TDM: one bit.
                if (frame_format_field == tdm_pkg::FMT_STD) begin
                    d.ws = (nx[9:5] == 5'h00);
                end else begin
                    d.ws = (nx == 10'h000);
                end
                if (nx[4:0] == 5'h00) begin
                    d.tx_sh = tx_data;
                    d.take  = 1'b1;
                end else begin
                    d.tx_sh = {q.tx_sh[30:0], 1'b0};
                end
            end else begin
                // Rising edge: sample the current bit.
                d.rx_sh = {q.rx_sh[30:0], cur_s};
                if ((q.cnt[4:0] == tdm_pkg::SLOT_LAST)
                    && (q.cnt[8:5] == slot_select_field)) begin
                    d.cur     = d.rx_sh[31:17];
                    d.cur_vld = 1'b1;
                end
            end
        end else begin
            d.div = q.div + 3'h1;
        end
    end

    // =================================================================
    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= HOST_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    assign link.bit_clock_pin      = q.bclk;
    assign link.word_select_pin    = q.ws;
    assign link.serial_data_in_pin = q.tx_sh[31];
    assign tx_take                 = q.take;
    assign cur_word                = q.cur;
    assign cur_valid               = q.cur_vld;
endmodule : tdm_host
`default_nettype wire

// [bench/tdm_link_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Protocol checks on the link.
module tdm_link_properties (
    input wire logic clk,                    // System clock.
    input wire logic rst,                    // Reset, active high.
    input wire logic bit_clock_pin,          // Bit clock.
    input wire logic word_select_pin,        // Frame marker.
    input wire logic serial_data_in_pin,     // Audio data.
    input wire logic current_stream_out_pin  // Current words.
);
    logic       bprev_q, wsprev_q, seen_q;
    logic [9:0] cnt_q, wsh_q;
    logic [2:0] age_q;
    logic       brise, wsrise, wsfall;
    logic [4:0] idx;

    // Bit clock rises and marker edges at them.
    assign brise  = bit_clock_pin & ~bprev_q;
    assign wsrise = brise & word_select_pin & ~wsprev_q;
    assign wsfall = brise & ~word_select_pin & wsprev_q;
    assign idx    = cnt_q[4:0] + 5'h01;

    // Bit index, marker run and clock edge age.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bprev_q  <= 1'b0;
            wsprev_q <= 1'b0;
            seen_q   <= 1'b0;
            cnt_q    <= 10'h000;
            wsh_q    <= 10'h000;
            age_q    <= 3'h7;
        end else begin
            bprev_q <= bit_clock_pin;
            // Saturate so a stopped clock cannot wrap into a fresh edge.
            age_q <= (bit_clock_pin != bprev_q) ? 3'h0 :
                     ((age_q == 3'h7) ? age_q : age_q + 3'h1);
            if (brise) begin
                wsprev_q <= word_select_pin;
                cnt_q    <= wsrise ? 10'h000 : cnt_q + 10'h001;
                wsh_q    <= word_select_pin ? wsh_q + 10'h001 : 10'h000;
                seen_q   <= seen_q | wsrise;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    bclk_high_a: assert property ($rose(bit_clock_pin) |->
        bit_clock_pin [*8] ##1 !bit_clock_pin) else $error("bit clock high phase wrong");
    bclk_low_a: assert property ($fell(bit_clock_pin) |->
        !bit_clock_pin [*8] ##1 bit_clock_pin) else $error("bit clock low phase wrong");
    ws_setup_a: assert property ($changed(word_select_pin) |->
        !bit_clock_pin) else $error("word select moved while clock high");
    data_setup_a: assert property ($changed(serial_data_in_pin) |->
        !bit_clock_pin) else $error("serial data moved while clock high");
    frame_len_a: assert property (wsrise && seen_q |-> cnt_q == 10'h03F ||
        cnt_q == 10'h07F || cnt_q == 10'h0FF || cnt_q == 10'h1FF)
        else $error("frame length not a legal bit count");
    ws_width_a: assert property (wsfall |->
        wsh_q == 10'h001 || wsh_q == 10'h020) else $error("word select width wrong");
    cur_pad_a: assert property (brise && seen_q && !wsrise && idx >= 5'h0F |->
        !current_stream_out_pin) else $error("current word padding not zero");
    cur_edge_a: assert property ($changed(current_stream_out_pin) |->
        age_q <= 3'h6) else $error("current bit launched off edge");

    cover property (wsrise && seen_q);
    cover property (brise && current_stream_out_pin);
    cover property (wsfall && wsh_q == 10'h020);
endmodule : tdm_link_properties
`default_nettype wire

// [bench/test_tdm_audio_rx_current_tx.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Joined ends, plus a second device driven by the bench.
module test_tdm_audio_rx_current_tx;
    logic               clk = 1'b0, rst = 1'b1, cfgw = 1'b0, esel = 1'b0;
    logic               ce = 1'b1, amp = 1'b1, clr = 1'b0;
    logic [1:0]         fmt = 2'h0, os = 2'h1, fsr = 2'h0;
    logic [3:0]         slot = 4'h0;
    logic [2:0]         rate = 3'h1, mon = 3'h3;
    logic signed [15:0] pos = 16'sh2000, neg = 16'shE000;
    logic [31:0]        tx_data = 32'h5A0000C3;
    logic [15:0]        k_q = 16'h0000;
    logic [23:0]        audio;
    logic [14:0]        cur;
    logic               av, ferr, stby, take, cv, ferr2, stby2;
    int                 fail_count = 0, comparisons = 0;
    tdm_link_if link ();
    tdm_link_if link2 ();

    always #5 clk = ~clk;
    initial begin
        link2.bit_clock_pin = 1'b0;
        link2.word_select_pin = 1'b0;
        link2.serial_data_in_pin = 1'b0;
    end
    // Numbered slot words; the device drops the low byte.
    always @(posedge clk) begin
        if (take === 1'b1) begin
            k_q <= k_q + 16'h0001;
            tx_data <= {8'h5A, k_q + 16'h0001, 8'hC3};
        end
    end

    tdm_dev u_tdm_dev (.clk(clk), .rst(rst), .ce(ce), .link(link),
        .cfg_write(cfgw), .frame_format_field(fmt), .slot_select_field(slot),
        .sample_rate_field(rate), .oversample_setting(os),
        .monitor_mode_field(mon), .sense_full_scale_field(fsr),
        .monitor_edge_select(esel), .amp_mute_or_play(amp), .sense_pos(pos),
        .sense_neg(neg), .frame_error_clear(clr), .audio_sample(audio),
        .audio_valid(av), .frame_error_flag(ferr), .force_standby(stby));
    tdm_dev u_tdm_dev_b (.clk(clk), .rst(rst), .ce(ce), .link(link2),
        .cfg_write(cfgw), .frame_format_field(fmt), .slot_select_field(slot),
        .sample_rate_field(rate), .oversample_setting(os),
        .monitor_mode_field(mon), .sense_full_scale_field(fsr),
        .monitor_edge_select(esel), .amp_mute_or_play(amp), .sense_pos(pos),
        .sense_neg(neg), .frame_error_clear(clr), .audio_sample(),
        .audio_valid(), .frame_error_flag(ferr2), .force_standby(stby2));
    tdm_host u_tdm_host (.clk(clk), .rst(rst), .ce(1'b1), .link(link),
        .frame_format_field(fmt), .slot_select_field(slot),
        .tx_data(tx_data), .tx_take(take), .cur_word(cur), .cur_valid(cv));
    tdm_link_properties u_tdm_link_properties (.clk(clk), .rst(rst),
        .bit_clock_pin(link.bit_clock_pin),
        .word_select_pin(link.word_select_pin),
        .serial_data_in_pin(link.serial_data_in_pin),
        .current_stream_out_pin(link.current_stream_out_pin));

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task cfg();
        @(posedge clk) cfgw <= 1'b1;
        @(posedge clk) cfgw <= 1'b0;
    endtask : cfg
    task restart(input logic [1:0] f);
        @(posedge clk) rst <= 1'b1;
        fmt <= f;
        slot <= 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cfg();
    endtask : restart
    // Waits for an audio (sel 0) or current (sel 1) word.
    task wait_pulse(input logic sel, output logic [31:0] v);
        int n;
        n = 0;
        do begin @(posedge clk); #1; n++; end
        while (((sel ? cv : av) !== 1'b1) && n < 20000);
        chk("word pulse", 32'(n < 20000), 32'h1);
        v = sel ? {17'h0, cur} : {8'h0, audio};
    endtask : wait_pulse
    task test_format(input logic [1:0] f, input logic [4:0] nslots);
        logic [31:0] a, b, c;
        restart(f);
        wait_pulse(1'b0, a);
        wait_pulse(1'b0, b);
        chk("audio top", 32'(b[23:16]), 32'h5A);
        chk("slot step", 32'(b[15:0] - a[15:0]), 32'(nslots));
        wait_pulse(1'b1, c);
        chk("current tdm", c, 32'h800);
        chk("flags", {30'h0, ferr, stby}, 32'h0);
        $display("format %0d test done", f);
    endtask : test_format
    task test_slot();
        logic [31:0] a, b;
        restart(2'h2);
        wait_pulse(1'b0, a);
        @(posedge clk) slot <= 4'h7;
        cfg();
        wait_pulse(1'b0, b);
        wait_pulse(1'b0, b);
        chk("slot pick", (b - a) & 32'h7, 32'h7);
        $display("slot test done");
    endtask : test_slot
    task cur_case(input logic [2:0] m, input logic a, input logic s,
                  input logic [2:0] r,
                  input logic [1:0] o, input logic [1:0] f, input logic e,
                  input logic [14:0] x);
        logic [31:0] v;
        @(posedge clk);
        {mon, amp, rate, os, fsr, esel} <= {m, a, r, o, f, e};
        {pos, neg} <= s ? 32'hE0002000 : 32'h2000E000;
        cfg();
        repeat (2) wait_pulse(1'b1, v);
        chk("current", v, 32'(x));
    endtask : cur_case
    task send_bit(input logic w);
        @(posedge clk) link2.bit_clock_pin <= 1'b0;
        link2.word_select_pin <= w;
        link2.serial_data_in_pin <= ~link2.serial_data_in_pin;
        repeat (8) @(posedge clk);
        link2.bit_clock_pin <= 1'b1;
        repeat (7) @(posedge clk);
    endtask : send_bit
    task send_frame(input int len);
        for (int i = 0; i < len; i++) send_bit(i < 32);
    endtask : send_frame
    // Bench frames: one short, then a stopped clock.
    task test_faults();
        restart(2'h0);
        repeat (3) send_frame(64);
        send_bit(1'b1);
        chk("frame ok", 32'(ferr2), 32'h0);
        send_frame(62);
        send_frame(64);
        chk("frame short", 32'(ferr2), 32'h1);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (2) @(posedge clk);
        chk("frame clear", 32'(ferr2), 32'h0);
        repeat (83) @(posedge clk);
        chk("clock present", 32'(stby2), 32'h0);
        repeat (30) @(posedge clk);
        chk("clock lost", 32'(stby2), 32'h1);
        send_bit(1'b0);
        chk("clock back", 32'(stby2), 32'h0);
        $display("fault test done");
    endtask : test_faults
    task final_report();
        $display("%0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    // Main sequence.
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_format(2'h0, 5'd2);
        test_format(2'h1, 5'd4);
        test_format(2'h2, 5'd8);
        test_format(2'h3, 5'd16);
        test_slot();
        restart(2'h0);
        cur_case(3'h3, 1'b1, 1'b0, 3'h1, 2'h1, 2'h0, 1'b1, 15'h0800);
        cur_case(3'h3, 1'b1, 1'b1, 3'h1, 2'h1, 2'h0, 1'b0, 15'h7800);
        cur_case(3'h3, 1'b1, 1'b0, 3'h1, 2'h1, 2'h1, 1'b1, 15'h1000);
        cur_case(3'h3, 1'b1, 1'b0, 3'h1, 2'h1, 2'h3, 1'b0, 15'h3FFF);
        cur_case(3'h3, 1'b1, 1'b0, 3'h0, 2'h0, 2'h0, 1'b1, 15'h0700);
        cur_case(3'h3, 1'b1, 1'b0, 3'h1, 2'h2, 2'h0, 1'b0, 15'h0900);
        cur_case(3'h3, 1'b1, 1'b0, 3'h2, 2'h1, 2'h0, 1'b1, 15'h0400);
        cur_case(3'h3, 1'b1, 1'b0, 3'h3, 2'h1, 2'h0, 1'b0, 15'h0200);
        cur_case(3'h2, 1'b1, 1'b0, 3'h1, 2'h1, 2'h0, 1'b1, 15'h0000);
        cur_case(3'h3, 1'b0, 1'b0, 3'h1, 2'h1, 2'h0, 1'b0, 15'h0000);
        $display("current test done");
        test_faults();
        final_report();
    end
    // Watchdog against a hang.
    initial begin
        #900000;
        fail_count++;
        final_report();
    end
endmodule : test_tdm_audio_rx_current_tx
`default_nettype wire
